/* hw/fsag_pkg.sv */
// Constants, field positions and carrier types for the flags word and
// the segmented address generator. Assumes one processor clock domain.
// What this block does
// - Carry flag, bit 0, set on carry out of or borrow into the top bit.
// - Parity flag, bit 2, set when low result byte has even ones.
// - Aux carry flag, bit 4, set on carry or borrow at low nibble.
// - Zero flag, bit 6, set when the result is zero.
// - Sign flag, bit 7, copies the result's top bit.
// - Single step flag, bit 8, traps after next instruction; trap clears it.
// - Maskable interrupts are taken only while enable flag, bit 9, is set.
// - Direction flag, bit 10, set decrements string index, clear increments.
// - Overflow flag, bit 11, set when signed result does not fit.
// - Physical address is segment base shifted left four plus offset.
// - A segment spans at most 64K bytes through a 16-bit offset.
// - Code segment serves prefetch and immediate fetches.
// - Stack segment serves push, pop and base-pointer-based references.
// - Extra segment serves destination-indexed string accesses, no override.
// - Data segment serves every other data reference.
// - An override prefix replaces the implied segment for the operand.
// - Effective address is a 16-bit sum; carry out is dropped.
// - An 8-bit displacement is sign-extended to 16 bits.
// - Direct mode uses only the displacement.
// - Register indirect uses one of the two index or two base registers.
// - Based or indexed mode adds displacement to one base or index.
// - Based indexed adds base and index, plus optional displacement.
// - The flags word is a 16-bit register of result and control flags.
package fsag_pkg;
  localparam int unsigned FLAGS_W = 16;
  localparam int unsigned PADDR_W = 20;
  localparam int unsigned SEG_SHIFT = 4;
  localparam int unsigned BIT_CARRY = 0;
  localparam int unsigned BIT_PARITY = 2;
  localparam int unsigned BIT_AUX = 4;
  localparam int unsigned BIT_ZERO = 6;
  localparam int unsigned BIT_SIGN = 7;
  localparam int unsigned BIT_STEP = 8;
  localparam int unsigned BIT_IEN = 9;
  localparam int unsigned BIT_DIR = 10;
  localparam int unsigned BIT_OVF = 11;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] FLAGS_WMASK = 16'h0fd5;
  localparam logic [15:0] RESULT_MASK = 16'h08d5;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  typedef enum logic [2:0] {
    FSAG_OP_ADD = 3'b000,
    FSAG_OP_SUB = 3'b001,
    FSAG_OP_LOGIC = 3'b010,
    FSAG_OP_NONE = 3'b011
  } fsag_op_t;

  typedef enum logic [2:0] {
    FSAG_AM_DIRECT = 3'b000,
    FSAG_AM_INDIRECT = 3'b001,
    FSAG_AM_BASED = 3'b010,
    FSAG_AM_INDEXED = 3'b011,
    FSAG_AM_BASED_INDEXED = 3'b100
  } fsag_amode_t;

  typedef enum logic [1:0] {
    FSAG_SEG_EXTRA = 2'b00,
    FSAG_SEG_CODE = 2'b01,
    FSAG_SEG_STACK = 2'b10,
    FSAG_SEG_DATA = 2'b11
  } fsag_seg_t;

  typedef enum logic [1:0] {
    FSAG_REF_DATA = 2'b00,
    FSAG_REF_FETCH = 2'b01,
    FSAG_REF_STACK = 2'b10,
    FSAG_REF_STRING_DST = 2'b11
  } fsag_ref_t;

  typedef enum logic [1:0] {
    FSAG_ST_RUN = 2'b00,
    FSAG_ST_STEP_ARMED = 2'b01
  } fsag_state_t;

  typedef struct packed {
    logic valid;
    fsag_op_t op;
    logic word;
    logic [15:0] a;
    logic [15:0] b;
    logic carry_in;
    logic [15:0] result;
  } fsag_alu_t;

  typedef struct packed {
    logic valid;
    fsag_ref_t ref_kind;
    fsag_amode_t mode;
    logic use_bp;
    logic use_di;
    logic disp_present;
    logic disp_wide;
    logic [15:0] disp;
    logic ovr_valid;
    fsag_seg_t ovr_seg;
    logic [15:0] offset_in;
  } fsag_addr_req_t;
endpackage

/* hw/fsag_addr_calc.sv */
// Combinational effective-address and segment selection for one request.
// Assumes register values are stable in the cycle the request is valid.
`timescale 1ns/1ps
module fsag_addr_calc (
  // Request
  input wire fsag_pkg::fsag_addr_req_t i_req,
  // Register values
  input wire logic [15:0] i_general_base_reg,
  input wire logic [15:0] i_base_pointer_reg,
  input wire logic [15:0] i_src_index_reg,
  input wire logic [15:0] i_dest_index_reg,
  // Results
  output logic [15:0] o_eff_addr,
  output fsag_pkg::fsag_seg_t o_seg
);
  logic [15:0] disp16;
  logic [15:0] base_v;
  logic [15:0] index_v;

  // Sign extension of short displacements
  assign disp16 = i_req.disp_wide ? i_req.disp
                : {{8{i_req.disp[7]}}, i_req.disp[7:0]};
  assign base_v = i_req.use_bp ? i_base_pointer_reg : i_general_base_reg;
  assign index_v = i_req.use_di ? i_dest_index_reg : i_src_index_reg;

  always_comb
  begin
    o_eff_addr = 16'h0000;
    case (i_req.mode)
      fsag_pkg::FSAG_AM_DIRECT: o_eff_addr = disp16;
      fsag_pkg::FSAG_AM_INDIRECT:
        // No displacement here, so its flag picks a base over an index
        o_eff_addr = i_req.disp_present ? base_v : index_v;
      fsag_pkg::FSAG_AM_BASED: o_eff_addr = base_v + disp16;
      fsag_pkg::FSAG_AM_INDEXED: o_eff_addr = index_v + disp16;
      fsag_pkg::FSAG_AM_BASED_INDEXED:
        // 16-bit target drops the carry out of bit 15
        o_eff_addr = base_v + index_v
                   + (i_req.disp_present ? disp16 : 16'h0000);
      default: o_eff_addr = 16'h0000;
    endcase
    if (i_req.ref_kind == fsag_pkg::FSAG_REF_FETCH
        || i_req.ref_kind == fsag_pkg::FSAG_REF_STACK
        || i_req.ref_kind == fsag_pkg::FSAG_REF_STRING_DST)
    begin
      o_eff_addr = i_req.offset_in;
    end
  end

  // Implied segment, then override where it is allowed
  always_comb
  begin
    o_seg = fsag_pkg::FSAG_SEG_DATA;
    case (i_req.ref_kind)
      fsag_pkg::FSAG_REF_FETCH: o_seg = fsag_pkg::FSAG_SEG_CODE;
      fsag_pkg::FSAG_REF_STACK: o_seg = fsag_pkg::FSAG_SEG_STACK;
      fsag_pkg::FSAG_REF_STRING_DST:
        o_seg = fsag_pkg::FSAG_SEG_EXTRA;
      fsag_pkg::FSAG_REF_DATA:
      begin
        if (i_req.use_bp
            && (i_req.mode == fsag_pkg::FSAG_AM_BASED
            || i_req.mode == fsag_pkg::FSAG_AM_BASED_INDEXED
            || (i_req.mode == fsag_pkg::FSAG_AM_INDIRECT
            && i_req.disp_present)))
        begin
          o_seg = fsag_pkg::FSAG_SEG_STACK;
        end
        if (i_req.ovr_valid)
        begin
          o_seg = i_req.ovr_seg;
        end
      end
      default: o_seg = fsag_pkg::FSAG_SEG_DATA;
    endcase
  end
endmodule

/* hw/fsag_top.sv */
// Processor flags word and segmented physical address generator.
// Assumes the sequencer supplies ALU results, instruction boundaries and
// address requests on the processor clock; the flags word is read and
// written directly by the core through the flags port.
`timescale 1ns/1ps
module fsag_top (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // ALU result for flag update
  input wire fsag_pkg::fsag_alu_t i_alu,
  // Direct access to the flags word
  input wire logic i_flags_we,
  input wire logic [15:0] i_flags_wdata,
  // Instruction sequencing
  input wire logic i_instr_done,
  input wire logic i_irq_req,
  input wire logic i_string_step,
  input wire logic i_string_word,
  // Segment registers
  input wire logic [15:0] i_code_segment_reg,
  input wire logic [15:0] i_stack_segment_reg,
  input wire logic [15:0] i_data_segment_reg,
  input wire logic [15:0] i_extra_segment_reg,
  // Base and index registers
  input wire logic [15:0] i_general_base_reg,
  input wire logic [15:0] i_base_pointer_reg,
  input wire logic [15:0] i_src_index_reg,
  input wire logic [15:0] i_dest_index_reg,
  // Address request
  input wire fsag_pkg::fsag_addr_req_t i_addr_req,
  // Flags and traps
  output logic [15:0] o_processor_flags_word,
  output logic o_step_trap,
  output logic o_irq_take,
  // String index adjust
  output logic o_index_upd,
  output logic [15:0] o_index_delta,
  // Address results
  output logic o_addr_valid,
  output logic [15:0] o_eff_addr,
  output fsag_pkg::fsag_seg_t o_seg,
  output logic [19:0] o_phys_addr
);
  logic [15:0] processor_flags_word;
  logic [15:0] next_flags;
  logic [16:0] sum17;
  logic [4:0] nib5;
  logic [15:0] res;
  logic msb_a;
  logic msb_b;
  logic msb_r;
  logic cy;
  logic ovf;
  fsag_pkg::fsag_state_t step_state;
  logic step_fire;
  logic [15:0] ea;
  fsag_pkg::fsag_seg_t seg;
  logic [15:0] seg_base;
  logic [19:0] phys;

  // Arithmetic for flag derivation
  always_comb
  begin
    sum17 = 17'h00000;
    nib5 = 5'h00;
    res = i_alu.result;
    case (i_alu.op)
      fsag_pkg::FSAG_OP_ADD:
      begin
        sum17 = {1'b0, i_alu.a} + {1'b0, i_alu.b}
              + {16'h0000, i_alu.carry_in};
        nib5 = {1'b0, i_alu.a[3:0]} + {1'b0, i_alu.b[3:0]}
             + {4'h0, i_alu.carry_in};
        res = sum17[15:0];
      end
      fsag_pkg::FSAG_OP_SUB:
      begin
        sum17 = {1'b0, i_alu.a} - {1'b0, i_alu.b}
              - {16'h0000, i_alu.carry_in};
        nib5 = {1'b0, i_alu.a[3:0]} - {1'b0, i_alu.b[3:0]}
             - {4'h0, i_alu.carry_in};
        res = sum17[15:0];
      end
      default:
      begin
        sum17 = 17'h00000;
        nib5 = 5'h00;
      end
    endcase
  end

  // Width-dependent top bit, carry and overflow
  always_comb
  begin
    if (i_alu.word)
    begin
      msb_a = i_alu.a[15];
      msb_b = i_alu.b[15];
      msb_r = res[15];
      cy = sum17[16];
    end
    else
    begin
      msb_a = i_alu.a[7];
      msb_b = i_alu.b[7];
      msb_r = res[7];
      cy = i_alu.a[8] ^ i_alu.b[8] ^ sum17[8];
    end
    ovf = 1'b0;
    if (i_alu.op == fsag_pkg::FSAG_OP_ADD)
    begin
      ovf = (msb_a == msb_b) && (msb_r != msb_a);
    end
    else if (i_alu.op == fsag_pkg::FSAG_OP_SUB)
    begin
      ovf = (msb_a != msb_b) && (msb_r != msb_a);
    end
  end

  // Single step trap fires on the boundary after the armed instruction
  assign step_fire = i_instr_done
                   && step_state == fsag_pkg::FSAG_ST_STEP_ARMED;

  always_comb
  begin
    next_flags = processor_flags_word;
    if (i_flags_we)
    begin
      next_flags = i_flags_wdata & fsag_pkg::FLAGS_WMASK;
    end
    if (i_alu.valid && i_alu.op != fsag_pkg::FSAG_OP_NONE)
    begin
      next_flags = next_flags & ~fsag_pkg::RESULT_MASK;
      next_flags[fsag_pkg::BIT_CARRY] =
        (i_alu.op == fsag_pkg::FSAG_OP_LOGIC) ? 1'b0 : cy;
      next_flags[fsag_pkg::BIT_PARITY] = ~(^res[7:0]);
      next_flags[fsag_pkg::BIT_AUX] =
        (i_alu.op == fsag_pkg::FSAG_OP_LOGIC) ? 1'b0 : nib5[4];
      next_flags[fsag_pkg::BIT_ZERO] =
        i_alu.word ? (res == 16'h0000) : (res[7:0] == 8'h00);
      next_flags[fsag_pkg::BIT_SIGN] = msb_r;
      next_flags[fsag_pkg::BIT_OVF] = ovf;
    end
    if (step_fire)
    begin
      // The trap's clear wins over a write in the same cycle
      next_flags[fsag_pkg::BIT_STEP] = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      processor_flags_word <= fsag_pkg::FLAGS_RESET;
    end
    else
    begin
      processor_flags_word <= next_flags;
    end
  end

  // Arm on the boundary where the step flag is seen set
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      step_state <= fsag_pkg::FSAG_ST_RUN;
    end
    else
    begin
      case (step_state)
        fsag_pkg::FSAG_ST_RUN:
          if (i_instr_done && processor_flags_word[fsag_pkg::BIT_STEP])
          begin
            step_state <= fsag_pkg::FSAG_ST_STEP_ARMED;
          end
        fsag_pkg::FSAG_ST_STEP_ARMED:
          if (i_instr_done)
          begin
            step_state <= fsag_pkg::FSAG_ST_RUN;
          end
        default: step_state <= fsag_pkg::FSAG_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_step_trap <= 1'b0;
      o_irq_take <= 1'b0;
    end
    else
    begin
      o_step_trap <= step_fire;
      o_irq_take <= i_irq_req && i_instr_done
                  && processor_flags_word[fsag_pkg::BIT_IEN];
    end
  end

  // String index step, two's complement for decrement
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_index_upd <= 1'b0;
      o_index_delta <= 16'h0000;
    end
    else
    begin
      o_index_upd <= i_string_step;
      if (processor_flags_word[fsag_pkg::BIT_DIR])
      begin
        o_index_delta <= i_string_word ? -fsag_pkg::WORD_STEP
                       : -fsag_pkg::BYTE_STEP;
      end
      else
      begin
        o_index_delta <= i_string_word ? fsag_pkg::WORD_STEP
                       : fsag_pkg::BYTE_STEP;
      end
    end
  end

  fsag_addr_calc u_calc (
    .i_req(i_addr_req),
    .i_general_base_reg(i_general_base_reg),
    .i_base_pointer_reg(i_base_pointer_reg),
    .i_src_index_reg(i_src_index_reg),
    .i_dest_index_reg(i_dest_index_reg),
    .o_eff_addr(ea),
    .o_seg(seg)
  );

  always_comb
  begin
    case (seg)
      fsag_pkg::FSAG_SEG_CODE: seg_base = i_code_segment_reg;
      fsag_pkg::FSAG_SEG_STACK: seg_base = i_stack_segment_reg;
      fsag_pkg::FSAG_SEG_EXTRA: seg_base = i_extra_segment_reg;
      default: seg_base = i_data_segment_reg;
    endcase
  end

  // Offset is only 16 bits, so no access leaves its 64K segment
  assign phys = {seg_base, 4'h0}
              + {4'h0, ea};

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_addr_valid <= 1'b0;
      o_eff_addr <= 16'h0000;
      o_seg <= fsag_pkg::FSAG_SEG_DATA;
      o_phys_addr <= 20'h00000;
    end
    else
    begin
      o_addr_valid <= i_addr_req.valid;
      o_eff_addr <= ea;
      o_seg <= seg;
      o_phys_addr <= phys;
    end
  end

  assign o_processor_flags_word = processor_flags_word;
endmodule

/* testbench/fsag_monitor.sv */
// Concurrent checks on the flags word, traps, string step and address
// outputs. Sees only fsag_top ports; attached by the bind below.
`timescale 1ns/1ps
module fsag_monitor (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Inputs watched
  input wire fsag_pkg::fsag_alu_t i_alu,
  input wire logic i_instr_done,
  input wire logic i_irq_req,
  input wire logic i_string_step,
  input wire logic i_string_word,
  input wire logic [15:0] i_code_segment_reg,
  input wire logic [15:0] i_stack_segment_reg,
  input wire logic [15:0] i_data_segment_reg,
  input wire logic [15:0] i_extra_segment_reg,
  input wire fsag_pkg::fsag_addr_req_t i_addr_req,
  // Outputs watched
  input wire logic [15:0] o_processor_flags_word,
  input wire logic o_step_trap,
  input wire logic o_irq_take,
  input wire logic o_index_upd,
  input wire logic [15:0] o_index_delta,
  input wire logic o_addr_valid,
  input wire logic [15:0] o_eff_addr,
  input wire fsag_pkg::fsag_seg_t o_seg,
  input wire logic [19:0] o_phys_addr
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic [16:0] sum_w;
  logic add_w;
  logic aux_w;
  logic ovf_w;
  logic [15:0] fw;
  logic [15:0] seg_q [4];
  // Segment values are sampled with the request, so keep a copy
  always_ff @(posedge i_sys_clk)
  begin
    seg_q[0] <= i_extra_segment_reg;
    seg_q[1] <= i_code_segment_reg;
    seg_q[2] <= i_stack_segment_reg;
    seg_q[3] <= i_data_segment_reg;
  end
  assign fw = o_processor_flags_word;
  assign sum_w = {1'b0, i_alu.a} + {1'b0, i_alu.b};
  assign add_w = i_alu.valid && i_alu.word && !i_alu.carry_in &&
    i_alu.op == fsag_pkg::FSAG_OP_ADD;
  assign aux_w = i_alu.a[4] ^ i_alu.b[4] ^ sum_w[4];
  assign ovf_w = (i_alu.a[15] == i_alu.b[15]) && (sum_w[15] != i_alu.a[15]);
  AST_CARRY: assert property (add_w |=> fw[0] == $past(sum_w[16]))
    else $error("carry flag wrong after add");
  AST_PARITY: assert property (add_w |=> fw[2] == $past(~^sum_w[7:0]))
    else $error("parity flag wrong after add");
  AST_AUX: assert property (add_w |=> fw[4] == $past(aux_w))
    else $error("aux carry flag wrong after add");
  AST_ZERO: assert property (add_w |=>
    fw[6] == ($past(sum_w[15:0]) == 0))
    else $error("zero flag wrong after add");
  AST_SIGN: assert property (add_w |=> fw[7] == $past(sum_w[15]))
    else $error("sign flag wrong after add");
  AST_OVF: assert property (add_w |=> fw[11] == $past(ovf_w))
    else $error("overflow flag wrong after add");
  AST_STEP: assert property (o_step_trap |-> ##[0:1] !fw[8])
    else $error("step trap left step flag set");
  AST_IRQ: assert property (o_irq_take |->
    $past(i_irq_req && i_instr_done && fw[9]))
    else $error("interrupt taken without enable");
  AST_DIR: assert property (i_string_step |=> o_index_upd &&
    o_index_delta == ($past(fw[10]) ?
    ($past(i_string_word) ? 16'hfffe : 16'hffff) :
    ($past(i_string_word) ? 16'h0002 : 16'h0001)))
    else $error("string index step wrong");
  AST_PHYS: assert property (o_addr_valid |-> o_phys_addr ==
    {seg_q[o_seg], 4'h0} + {4'h0, o_eff_addr})
    else $error("physical address wrong");
  AST_FETCH: assert property (i_addr_req.valid &&
    i_addr_req.ref_kind == fsag_pkg::FSAG_REF_FETCH |=> o_addr_valid &&
    o_seg == fsag_pkg::FSAG_SEG_CODE &&
    o_eff_addr == $past(i_addr_req.offset_in))
    else $error("fetch not in code segment");
  AST_STRDST: assert property (i_addr_req.valid &&
    i_addr_req.ref_kind == fsag_pkg::FSAG_REF_STRING_DST |=>
    o_addr_valid && o_seg == fsag_pkg::FSAG_SEG_EXTRA)
    else $error("string destination not in extra segment");
  COV_IRQ: cover property (o_irq_take);
  COV_STEP: cover property (o_step_trap);
  COV_EXTRA: cover property (o_addr_valid &&
    o_seg == fsag_pkg::FSAG_SEG_EXTRA);
endmodule
bind fsag_top fsag_monitor fsag_monitor_inst (.i_sys_clk(i_sys_clk),
  .i_rst(i_rst), .i_alu(i_alu), .i_instr_done(i_instr_done),
  .i_irq_req(i_irq_req), .i_string_step(i_string_step),
  .i_string_word(i_string_word), .i_code_segment_reg(i_code_segment_reg),
  .i_stack_segment_reg(i_stack_segment_reg),
  .i_data_segment_reg(i_data_segment_reg),
  .i_extra_segment_reg(i_extra_segment_reg), .i_addr_req(i_addr_req),
  .o_processor_flags_word(o_processor_flags_word),
  .o_step_trap(o_step_trap), .o_irq_take(o_irq_take),
  .o_index_upd(o_index_upd), .o_index_delta(o_index_delta),
  .o_addr_valid(o_addr_valid), .o_eff_addr(o_eff_addr), .o_seg(o_seg),
  .o_phys_addr(o_phys_addr));

/* testbench/tb_top.sv */
// Self-checking bench for fsag_top: flags, traps, string step, addresses.
// Drives every port directly 1 ns after the rising clock edge.
`timescale 1ns/1ps
module tb_top;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  fsag_pkg::fsag_alu_t i_alu = '0;
  logic i_flags_we = 1'b0;
  logic [15:0] i_flags_wdata = 16'h0000;
  logic i_instr_done = 1'b0;
  logic i_irq_req = 1'b0;
  logic i_string_step = 1'b0;
  logic i_string_word = 1'b0;
  // Data segment near the top so that the physical sum wraps
  logic [15:0] seg_code = 16'hf000;
  logic [15:0] seg_stack = 16'h3000;
  logic [15:0] seg_data = 16'hffff;
  logic [15:0] seg_extra = 16'h5000;
  logic [15:0] r_base = 16'h1000;
  logic [15:0] r_bptr = 16'h2000;
  logic [15:0] r_src = 16'h0030;
  logic [15:0] r_dst = 16'h0400;
  fsag_pkg::fsag_addr_req_t i_addr_req = '0;
  logic [15:0] o_processor_flags_word;
  logic o_step_trap;
  logic o_irq_take;
  logic o_index_upd;
  logic [15:0] o_index_delta;
  logic o_addr_valid;
  logic [15:0] o_eff_addr;
  fsag_pkg::fsag_seg_t o_seg;
  logic [19:0] o_phys_addr;
  int num_errors = 0;
  int num_checks = 0;
  fsag_top fsag_top_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_alu(i_alu), .i_flags_we(i_flags_we), .i_flags_wdata(i_flags_wdata),
    .i_instr_done(i_instr_done), .i_irq_req(i_irq_req),
    .i_string_step(i_string_step), .i_string_word(i_string_word),
    .i_code_segment_reg(seg_code), .i_stack_segment_reg(seg_stack),
    .i_data_segment_reg(seg_data), .i_extra_segment_reg(seg_extra),
    .i_general_base_reg(r_base), .i_base_pointer_reg(r_bptr),
    .i_src_index_reg(r_src), .i_dest_index_reg(r_dst),
    .i_addr_req(i_addr_req), .o_processor_flags_word(o_processor_flags_word),
    .o_step_trap(o_step_trap), .o_irq_take(o_irq_take),
    .o_index_upd(o_index_upd), .o_index_delta(o_index_delta),
    .o_addr_valid(o_addr_valid), .o_eff_addr(o_eff_addr), .o_seg(o_seg),
    .o_phys_addr(o_phys_addr));
  initial
  begin
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  task automatic tick();
    @(posedge i_sys_clk);
    #1;
  endtask
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [15:0] d);
    i_flags_we = 1'b1;
    i_flags_wdata = d;
    tick();
    i_flags_we = 1'b0;
    // Let an edge pass so a following write raises the strobe afresh
    tick();
  endtask
  // Operand bits above the width are zero, so bit m+1 is carry or borrow
  task automatic alu(input logic [2:0] op, input logic w,
    input logic [15:0] a, input logic [15:0] b, input logic [15:0] res);
    logic [16:0] r;
    logic [15:0] e;
    logic lg;
    int m;
    m = w ? 15 : 7;
    lg = (op == 3'h2);
    r = (op == 3'h1) ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    if (lg)
      r = {1'b0, res};
    e = '0;
    e[0] = !lg && r[m + 1];
    e[2] = ~^r[7:0];
    e[4] = !lg && (a[4] ^ b[4] ^ r[4]);
    e[6] = w ? (r[15:0] == 0) : (r[7:0] == 0);
    e[7] = r[m];
    e[11] = !lg && ((a[m] ^ b[m]) == (op == 3'h1)) && (r[m] != a[m]);
    i_alu = '{1'b1, fsag_pkg::fsag_op_t'(op), w, a, b, 1'b0, res};
    tick();
    check(o_processor_flags_word & fsag_pkg::RESULT_MASK,
      e);
  endtask
  task automatic t_alu();
    alu(3'h0, 1'b1, 16'hffff, 16'h0001, 16'h0000);
    alu(3'h0, 1'b1, 16'h7fff, 16'h0001, 16'h0000);
    alu(3'h1, 1'b1, 16'h0000, 16'h0001, 16'h0000);
    alu(3'h0, 1'b0, 16'h007f, 16'h0001, 16'h0000);
    alu(3'h1, 1'b0, 16'h0080, 16'h0001, 16'h0000);
    alu(3'h0, 1'b0, 16'h00ff, 16'h0001, 16'h0000);
    alu(3'h2, 1'b1, 16'hffff, 16'hffff, 16'h0000);
    alu(3'h2, 1'b1, 16'h0000, 16'h0000, 16'h8001);
    // An idle operation must leave every result flag alone
    i_alu = '{1'b1, fsag_pkg::FSAG_OP_NONE, 1'b1, 16'hffff, 16'h0001,
      1'b0, 16'h0000};
    tick();
    check(o_processor_flags_word, 16'h0080);
    i_alu.valid = 1'b0;
    wr(16'hffff);
    check(o_processor_flags_word, 16'h0fd5);
    $display("alu and flags word test done");
  endtask
  task automatic t_step();
    wr(16'h0100);
    i_instr_done = 1'b1;
    tick();
    check(o_step_trap, 1'b0);
    tick();
    check(o_step_trap, 1'b1);
    check(o_processor_flags_word[8], 1'b0);
    i_instr_done = 1'b0;
    tick();
    check(o_step_trap, 1'b0);
    i_irq_req = 1'b1;
    i_instr_done = 1'b1;
    tick();
    check(o_irq_take, 1'b0);
    i_instr_done = 1'b0;
    wr(16'h0200);
    i_instr_done = 1'b1;
    tick();
    check(o_irq_take, 1'b1);
    i_instr_done = 1'b0;
    i_irq_req = 1'b0;
    $display("step and interrupt test done");
  endtask
  task automatic sstep(input logic w, input logic [15:0] exp);
    i_string_step = 1'b1;
    i_string_word = w;
    tick();
    check(o_index_upd, 1'b1);
    check(o_index_delta, exp);
  endtask
  task automatic t_dir();
    wr(16'h0000);
    sstep(1'b0, 16'h0001);
    sstep(1'b1, 16'h0002);
    i_string_step = 1'b0;
    wr(16'h0400);
    sstep(1'b0, 16'hffff);
    sstep(1'b1, 16'hfffe);
    i_string_step = 1'b0;
    $display("direction test done");
  endtask
  // sel is use_bp, use_di, disp_present, disp_wide; ov is valid and seg
  task automatic ag(input logic [1:0] rk, input logic [2:0] md,
    input logic [3:0] sel, input logic [15:0] dsp, input logic [2:0] ov,
    input logic [15:0] eff, input logic [1:0] sg);
    logic [15:0] base;
    i_addr_req = '{1'b1, fsag_pkg::fsag_ref_t'(rk),
      fsag_pkg::fsag_amode_t'(md), sel[3], sel[2], sel[1], sel[0], dsp,
      ov[2], fsag_pkg::fsag_seg_t'(ov[1:0]), dsp};
    tick();
    base = (sg == 2'h0) ? seg_extra : (sg == 2'h1) ? seg_code :
      (sg == 2'h2) ? seg_stack : seg_data;
    check(o_addr_valid, 1'b1);
    check(o_eff_addr, eff);
    check(o_seg, sg);
    check(o_phys_addr, {base, 4'h0} + {4'h0, eff});
  endtask
  task automatic t_addr();
    ag(2'h0, 3'h0, 4'h3, 16'h1234, 3'h0, 16'h1234, 2'h3);
    ag(2'h0, 3'h0, 4'h2, 16'h0080, 3'h0, 16'hff80, 2'h3);
    ag(2'h0, 3'h1, 4'h4, 16'h0000, 3'h0, 16'h0400, 2'h3);
    ag(2'h0, 3'h1, 4'h2, 16'h0000, 3'h0, 16'h1000, 2'h3);
    ag(2'h0, 3'h1, 4'ha, 16'h0000, 3'h0, 16'h2000, 2'h2);
    ag(2'h0, 3'h1, 4'h0, 16'h0000, 3'h0, 16'h0030, 2'h3);
    ag(2'h0, 3'h2, 4'ha, 16'h0080, 3'h0, 16'h1f80, 2'h2);
    ag(2'h0, 3'h3, 4'h7, 16'h0010, 3'h0, 16'h0410, 2'h3);
    ag(2'h0, 3'h4, 4'h0, 16'h0000, 3'h0, 16'h1030, 2'h3);
    ag(2'h0, 3'h4, 4'hf, 16'hfff0, 3'h0, 16'h23f0, 2'h2);
    ag(2'h0, 3'h2, 4'h3, 16'h0010, 3'h4, 16'h1010, 2'h0);
    ag(2'h1, 3'h0, 4'h0, 16'hfff0, 3'h7, 16'hfff0, 2'h1);
    ag(2'h2, 3'h0, 4'h0, 16'h0100, 3'h7, 16'h0100, 2'h2);
    ag(2'h3, 3'h0, 4'h0, 16'h0004, 3'h7, 16'h0004, 2'h0);
    i_addr_req.valid = 1'b0;
    tick();
    check(o_addr_valid, 1'b0);
    $display("address test done");
  endtask
  initial
  begin
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_rst = 1'b0;
    check(o_processor_flags_word, 16'h0000);
    check(o_seg, 2'h3);
    t_alu();
    t_step();
    t_dir();
    t_addr();
    end_sim();
  end
endmodule
